// ### shared/mcuvl_pkg.sv
// Package: constants for the firmware update validate and load block
// Assumes: one 50 MHz clock, model-register port driven by the core
package mcuvl_pkg;
  // ****************************************************************
  // Register addresses and fields
  // ****************************************************************
  localparam logic [31:0] ADDR_PLATFORM_ID   = 32'h0000_0017;
  localparam logic [31:0] ADDR_LOAD_TRIGGER  = 32'h0000_0079;
  localparam int          PLAT_LSB           = 50;
  localparam int          PLAT_MSB           = 52;
  localparam int          PLAT_W             = 3;
  localparam logic [31:0] HDR_VERSION_ONE    = 32'h0000_0001;
  localparam logic [31:0] LOADER_REV_ONE     = 32'h0000_0001;
  localparam logic [63:0] DATA_OFFSET        = 64'h0000_0000_0000_0030;
  localparam logic [63:0] ALIGN_MASK         = 64'h0000_0000_0000_000F;
  // ****************************************************************
  // Header layout in words, and sizes
  // ****************************************************************
  localparam logic [15:0] WIDX_HDR_VER       = 16'h0000;
  localparam logic [15:0] WIDX_LOADER_REV    = 16'h0005;
  localparam logic [15:0] WIDX_FLAGS         = 16'h0006;
  localparam logic [15:0] WIDX_DATA_SIZE     = 16'h0007;
  localparam logic [15:0] WIDX_TOTAL_SIZE    = 16'h0008;
  localparam logic [15:0] DEFAULT_WORDS      = 16'h0200;
  localparam logic [31:0] KBYTE_MASK         = 32'h0000_03FF;
  localparam logic [31:0] SUM_ZERO           = 32'h0000_0000;
  localparam logic [2:0]  TOTAL_SHIFT        = 3'h2;
  // ****************************************************************
  // Loader states, Gray along the usual path
  // ****************************************************************
  typedef enum logic [2:0]
  {
    MCUVL_IDLE  = 3'h0,
    MCUVL_SUM   = 3'h1,
    MCUVL_CHECK = 3'h3,
    MCUVL_DONE  = 3'h2
  } mcuvl_state_t;
endpackage

// ### hdl/mcuvl_word_sum.sv
// Word sum: wrapping 32-bit unsigned accumulator over image words
// Assumes: caller clears before a pass and presents one word per strobe
`timescale 1ns/100ps
module mcuvl_word_sum
(
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic        i_clear,
  input  wire logic        i_add,
  input  wire logic [31:0] i_word,
  output logic      [31:0] o_sum
);
  logic [31:0] word_sum_accumulator;
  logic [31:0] next_word_sum_accumulator;

  // ****************************************************************
  // Accumulate
  // ****************************************************************
  always_comb
  begin
    next_word_sum_accumulator = word_sum_accumulator;
    if (i_clear)
    begin
      next_word_sum_accumulator = mcuvl_pkg::SUM_ZERO;
    end
    else if (i_add)
    begin
      next_word_sum_accumulator = word_sum_accumulator + i_word;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      word_sum_accumulator <= mcuvl_pkg::SUM_ZERO;
    end
    else
    begin
      word_sum_accumulator <= next_word_sum_accumulator;
    end
  end

  assign o_sum = word_sum_accumulator;
endmodule

// ### hdl/mcuvl_top.sv
// Top: platform id register, load trigger, image check and load
// Assumes: core drives model-register reads and writes, image memory
// answers one word per valid pulse at the fetched word index
//
// Function
// - Platform id is 64-bit read-only at model address 17H, quadword reads.
// - Bits 52:50 hold platform value; all other bits reserved, read zero.
// - Image fits platform only when flag bit chosen by platform value set.
// - Trigger sequence depends on loader revision; revision one supported.
// - Write to 79H holds update data address, image start plus 48.
// - Hard reset discards loaded update; loader repeats it.
// - INIT keeps loaded update; reloading same update has no side effect.
`timescale 1ns/100ps
module mcuvl_top
(
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic        i_init,
  input  wire logic [2:0]  i_platform_strap,
  input  wire logic        i_mreg_rd,
  input  wire logic        i_mreg_wr,
  input  wire logic [31:0] i_mreg_addr,
  input  wire logic [63:0] i_mreg_wdata,
  output logic      [63:0] o_mreg_rdata,
  output logic             o_mreg_rvalid,
  output logic      [63:0] o_img_addr,
  output logic             o_img_rd,
  input  wire logic [31:0] i_img_word,
  input  wire logic        i_img_valid,
  output logic             o_busy,
  output logic             o_update_loaded,
  output logic             o_load_ok,
  output logic             o_load_reject
);
  // ****************************************************************
  // State
  // ****************************************************************
  mcuvl_pkg::mcuvl_state_t state;
  mcuvl_pkg::mcuvl_state_t next_state;
  logic [2:0]  platform;
  logic [63:0] base;
  logic [63:0] next_base;
  logic [15:0] widx;
  logic [15:0] next_widx;
  logic [15:0] nwords;
  logic [15:0] next_nwords;
  logic [31:0] hdr_ver;
  logic [31:0] next_hdr_ver;
  logic [31:0] ldr_rev;
  logic [31:0] next_ldr_rev;
  logic [31:0] flags;
  logic [31:0] next_flags;
  logic [31:0] tsize;
  logic [31:0] next_tsize;
  logic        loaded;
  logic        next_loaded;
  logic        ok;
  logic        next_ok;
  logic        rej;
  logic        next_rej;
  logic        rd;
  logic        next_rd;
  logic        rvalid;
  logic        next_rvalid;
  logic [63:0] rdata;
  logic [63:0] next_rdata;
  logic        sum_clear;
  logic        sum_add;
  logic [31:0] sum;
  logic        trig;
  logic        good;

  mcuvl_word_sum mcuvl_word_sum_inst
  (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_clear (sum_clear),
    .i_add   (sum_add),
    .i_word  (i_img_word),
    .o_sum   (sum)
  );

  // ****************************************************************
  // Platform strap, registered on every clock, reset has no effect
  // ****************************************************************
  always_ff @(posedge i_clock)
  begin
    platform <= i_platform_strap;
  end

  // ****************************************************************
  // Register port and load sequencer
  // ****************************************************************
  assign trig = i_mreg_wr && (i_mreg_addr == mcuvl_pkg::ADDR_LOAD_TRIGGER);
  assign good = (sum == mcuvl_pkg::SUM_ZERO)
             && (hdr_ver == mcuvl_pkg::HDR_VERSION_ONE)
             && (ldr_rev == mcuvl_pkg::LOADER_REV_ONE)
             && flags[platform]
             && ((tsize & mcuvl_pkg::KBYTE_MASK) == mcuvl_pkg::SUM_ZERO)
             && ((base & mcuvl_pkg::ALIGN_MASK) == 64'h0);

  always_comb
  begin
    next_state  = state;
    next_base   = base;
    next_widx   = widx;
    next_nwords = nwords;
    next_hdr_ver = hdr_ver;
    next_ldr_rev = ldr_rev;
    next_flags  = flags;
    next_tsize  = tsize;
    next_loaded = loaded;
    next_ok     = ok;
    next_rej    = rej;
    next_rd     = 1'b0;
    next_rvalid = 1'b0;
    next_rdata  = rdata;
    sum_clear   = 1'b0;
    sum_add     = 1'b0;
    if (i_mreg_rd)
    begin
      next_rvalid = 1'b1;
      next_rdata  = 64'h0;
      if (i_mreg_addr == mcuvl_pkg::ADDR_PLATFORM_ID)
      begin
        next_rdata[mcuvl_pkg::PLAT_MSB:mcuvl_pkg::PLAT_LSB] = platform;
      end
    end
    case (state)
      mcuvl_pkg::MCUVL_IDLE:
      begin
        if (trig)
        begin
          next_base   = i_mreg_wdata - mcuvl_pkg::DATA_OFFSET;
          next_widx   = 16'h0000;
          next_nwords = mcuvl_pkg::DEFAULT_WORDS;
          next_ok     = 1'b0;
          next_rej    = 1'b0;
          next_rd     = 1'b1;
          sum_clear   = 1'b1;
          next_state  = mcuvl_pkg::MCUVL_SUM;
        end
      end
      mcuvl_pkg::MCUVL_SUM:
      begin
        next_rd = 1'b1;
        if (i_img_valid)
        begin
          sum_add = 1'b1;
          if (widx == mcuvl_pkg::WIDX_HDR_VER)
            next_hdr_ver = i_img_word;
          if (widx == mcuvl_pkg::WIDX_LOADER_REV)
            next_ldr_rev = i_img_word;
          if (widx == mcuvl_pkg::WIDX_FLAGS)
            next_flags = i_img_word;
          if (widx == mcuvl_pkg::WIDX_TOTAL_SIZE)
            next_tsize = i_img_word;
          if (widx == mcuvl_pkg::WIDX_DATA_SIZE && i_img_word != 32'h0)
            next_nwords = 16'hFFFF;
          if (widx == mcuvl_pkg::WIDX_TOTAL_SIZE && nwords == 16'hFFFF)
            next_nwords = 16'(i_img_word >> mcuvl_pkg::TOTAL_SHIFT);
          next_widx = widx + 16'h0001;
          // A count at or below the index ends the pass, no wrap
          if ((widx + 16'h0001) >= next_nwords)
          begin
            next_rd    = 1'b0;
            next_state = mcuvl_pkg::MCUVL_CHECK;
          end
        end
      end
      mcuvl_pkg::MCUVL_CHECK:
      begin
        next_ok     = good;
        next_rej    = !good;
        next_loaded = loaded || good;
        next_state  = mcuvl_pkg::MCUVL_DONE;
      end
      default:
      begin
        next_state = mcuvl_pkg::MCUVL_IDLE;
      end
    endcase
    // INIT stops a pass but keeps the loaded update
    if (i_init)
    begin
      next_state = mcuvl_pkg::MCUVL_IDLE;
      next_rd    = 1'b0;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      state   <= mcuvl_pkg::MCUVL_IDLE;
      base    <= 64'h0;
      widx    <= 16'h0000;
      nwords  <= 16'h0000;
      hdr_ver <= 32'h0;
      ldr_rev <= 32'h0;
      flags   <= 32'h0;
      tsize   <= 32'h0;
      loaded  <= 1'b0;
      ok      <= 1'b0;
      rej     <= 1'b0;
      rd      <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 64'h0;
    end
    else
    begin
      state   <= next_state;
      base    <= next_base;
      widx    <= next_widx;
      nwords  <= next_nwords;
      hdr_ver <= next_hdr_ver;
      ldr_rev <= next_ldr_rev;
      flags   <= next_flags;
      tsize   <= next_tsize;
      loaded  <= next_loaded;
      ok      <= next_ok;
      rej     <= next_rej;
      rd      <= next_rd;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
    end
  end

  // ****************************************************************
  // Outputs; INIT leaves the loaded update untouched
  // ****************************************************************
  logic [63:0] img_addr;
  logic        busy;
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      img_addr <= 64'h0;
      busy     <= 1'b0;
    end
    else
    begin
      img_addr <= next_base + {46'h0, next_widx, 2'h0};
      busy     <= (next_state != mcuvl_pkg::MCUVL_IDLE);
    end
  end

  assign o_mreg_rdata    = rdata;
  assign o_mreg_rvalid   = rvalid;
  assign o_img_addr      = img_addr;
  assign o_img_rd        = rd;
  assign o_busy          = busy;
  assign o_update_loaded = loaded;
  assign o_load_ok       = ok;
  assign o_load_reject   = rej;
endmodule

// ### bench/mcuvl_props.sv
// Checker: port assertions for the update validate and load block
// Assumes: bound to mcuvl_top, one clock, sync active-high reset
`timescale 1ns/100ps
module mcuvl_props
(
  input wire logic        i_clock,
  input wire logic        i_rst,
  input wire logic        i_init,
  input wire logic [2:0]  i_platform_strap,
  input wire logic        i_mreg_rd,
  input wire logic [31:0] i_mreg_addr,
  input wire logic [63:0] o_mreg_rdata,
  input wire logic        o_mreg_rvalid,
  input wire logic [63:0] o_img_addr,
  input wire logic        o_img_rd,
  input wire logic        i_img_valid,
  input wire logic        o_busy,
  input wire logic        o_update_loaded,
  input wire logic        o_load_ok,
  input wire logic        o_load_reject
);
  // ****
  // Assertions
  // ****
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  AST_RD_ANSWER: assert property (i_mreg_rd |=> o_mreg_rvalid)
    else $error("read not answered");
  AST_RVALID_CAUSE: assert property (o_mreg_rvalid |-> $past(i_mreg_rd))
    else $error("answer without read");
  AST_PLAT_FIELD: assert property (i_mreg_rd &&
    i_mreg_addr == mcuvl_pkg::ADDR_PLATFORM_ID |=>
    o_mreg_rdata == {11'h000, $past(i_platform_strap, 2), 50'h0})
    else $error("platform field wrong");
  AST_UNMAPPED_ZERO: assert property (i_mreg_rd &&
    i_mreg_addr != mcuvl_pkg::ADDR_PLATFORM_ID |=> o_mreg_rdata == 64'h0)
    else $error("unmapped read not zero");
  AST_OK_XOR_REJ: assert property (!(o_load_ok && o_load_reject))
    else $error("ok and reject together");
  AST_LOADED_HOLD: assert property (o_update_loaded |=> o_update_loaded)
    else $error("loaded update lost");
  AST_OK_LOADS: assert property (o_load_ok |-> o_update_loaded)
    else $error("ok without loaded");
  AST_FETCH_STEP: assert property (o_img_rd && i_img_valid |=>
    !o_img_rd || o_img_addr == $past(o_img_addr) + 64'h4)
    else $error("fetch address step wrong");
  AST_FETCH_BUSY: assert property (o_img_rd |-> o_busy)
    else $error("fetch while idle");
  AST_INIT_IDLE: assert property (i_init |=> !o_busy)
    else $error("init did not stop the pass");
  // ****
  // Covers
  // ****
  COV_OK: cover property ($rose(o_load_ok));
  COV_REJ: cover property ($rose(o_load_reject));
  COV_STEP: cover property (o_img_rd && i_img_valid ##1 o_img_rd);
  COV_INIT: cover property (i_init && o_busy);
endmodule
bind mcuvl_top mcuvl_props mcuvl_props_inst (.i_clock(i_clock),
  .i_rst(i_rst), .i_init(i_init), .i_platform_strap(i_platform_strap),
  .i_mreg_rd(i_mreg_rd), .i_mreg_addr(i_mreg_addr),
  .o_mreg_rdata(o_mreg_rdata), .o_mreg_rvalid(o_mreg_rvalid),
  .o_img_addr(o_img_addr), .o_img_rd(o_img_rd),
  .i_img_valid(i_img_valid), .o_busy(o_busy),
  .o_update_loaded(o_update_loaded), .o_load_ok(o_load_ok),
  .o_load_reject(o_load_reject));

// ### bench/mcuvl_img_mem.sv
// Partner: image memory, one word per valid pulse, optional stall
// Assumes: image based at byte 2000H, at most 1024 words
`timescale 1ns/100ps
module mcuvl_img_mem
(
  input  wire logic        i_clock,
  input  wire logic        i_slow,
  input  wire logic [63:0] i_img_addr,
  input  wire logic        i_img_rd,
  output logic      [31:0] o_img_word = 32'h0,
  output logic             o_img_valid = 1'b0
);
  logic [31:0] mem [0:1023];
  logic [1:0]  wait_cnt = 2'h0;
  always_ff @(posedge i_clock)
  begin
    if (i_img_rd && !o_img_valid && wait_cnt == 2'h0)
    begin
      o_img_valid <= 1'b1;
      o_img_word  <= mem[i_img_addr[11:2]];
      wait_cnt    <= {i_slow, i_slow};
    end
    else
    begin
      o_img_valid <= 1'b0;
      o_img_word  <= ~o_img_word;
      if (wait_cnt != 2'h0)
        wait_cnt <= wait_cnt - 2'h1;
    end
  end
endmodule

// ### bench/mcuvl_top_test.sv
// Bench: register reads, image loads and reset handling
// Assumes: mcuvl_top, image memory partner, 50 MHz clock
`timescale 1ns/100ps
module mcuvl_top_test;
  logic        i_clock = 1'b0;
  logic        i_rst   = 1'b1;
  logic        i_init  = 1'b0;
  logic        slow    = 1'b0;
  logic [2:0]  strap   = 3'h0;
  logic        mrd     = 1'b0;
  logic        mwr     = 1'b0;
  logic [31:0] maddr   = 32'h0;
  logic [63:0] mwdata  = 64'h0;
  logic [63:0] rdata, img_addr, d;
  logic [31:0] img_word;
  logic        rvalid, img_rd, img_valid, busy, loaded, ok, rej;
  int          fails = 0;
  int          samples_checked = 0;
  // Core signature placed in every image; value is arbitrary
  localparam logic [31:0] CORE_SIG = 32'h0000_0A5C;
  mcuvl_top mcuvl_top_inst (.i_clock(i_clock), .i_rst(i_rst),
    .i_init(i_init), .i_platform_strap(strap), .i_mreg_rd(mrd),
    .i_mreg_wr(mwr), .i_mreg_addr(maddr), .i_mreg_wdata(mwdata),
    .o_mreg_rdata(rdata), .o_mreg_rvalid(rvalid), .o_img_addr(img_addr),
    .o_img_rd(img_rd), .i_img_word(img_word), .i_img_valid(img_valid),
    .o_busy(busy), .o_update_loaded(loaded), .o_load_ok(ok),
    .o_load_reject(rej));
  mcuvl_img_mem mcuvl_img_mem_inst (.i_clock(i_clock), .i_slow(slow),
    .i_img_addr(img_addr), .i_img_rd(img_rd), .o_img_word(img_word),
    .o_img_valid(img_valid));
  initial
  begin
    forever #10 i_clock = ~i_clock;
  end
  // ****
  // Tasks
  // ****
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [31:0] a, output logic [63:0] q);
    @(posedge i_clock) mrd <= 1'b1;
    maddr <= a;
    @(posedge i_clock) mrd <= 1'b0;
    #1 q = rdata;
    chk(64'(rvalid), 64'h1);
  endtask
  task automatic load(input logic [31:0] ver, rev, flg, dsz, tsz,
                      input logic [63:0] off, input logic bad, good);
    logic [31:0] s;
    int          n;
    int          o;
    s = 32'h0;
    n = (dsz == 32'h0) ? 512 : int'(tsz / 4);
    o = int'(off[11:2]);
    for (int i = 0; i < 1024; i++)
      mcuvl_img_mem_inst.mem[i] = 32'hF000_0000 + i;
    mcuvl_img_mem_inst.mem[o] = ver;
    mcuvl_img_mem_inst.mem[o + 3] = CORE_SIG;
    mcuvl_img_mem_inst.mem[o + 4] = 32'h0;
    mcuvl_img_mem_inst.mem[o + 5] = rev;
    mcuvl_img_mem_inst.mem[o + 6] = flg;
    mcuvl_img_mem_inst.mem[o + 7] = dsz;
    mcuvl_img_mem_inst.mem[o + 8] = tsz;
    for (int i = 0; i < n; i++)
      s += mcuvl_img_mem_inst.mem[o + i];
    mcuvl_img_mem_inst.mem[o + 4] = 32'h0 - s + {31'h0, bad};
    @(posedge i_clock) mwr <= 1'b1;
    maddr <= mcuvl_pkg::ADDR_LOAD_TRIGGER;
    mwdata <= 64'h2030 + off;
    @(posedge i_clock) mwr <= 1'b0;
    repeat (3) @(posedge i_clock);
    for (int k = 0; k < 4000 && busy !== 1'b0; k++)
      @(posedge i_clock);
    #1 chk(64'(busy), 64'h0);
    chk(64'(ok), 64'(good));
    chk(64'(rej), 64'(!good));
    $display("load test done at %0t", $time);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ****
  // Tests
  // ****
  initial
  begin
    repeat (60000) @(posedge i_clock);
    fails++;
    summarize();
  end
  initial
  begin
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    #1 chk(64'({ok, rej, loaded, busy}), 64'h0);
    for (int p = 0; p < 8; p++)
    begin
      @(posedge i_clock) strap <= p[2:0];
      rd(mcuvl_pkg::ADDR_PLATFORM_ID, d);
      chk(d, {11'h000, p[2:0], 50'h0});
    end
    rd(32'h0000_008B, d);
    chk(d, 64'h0);
    rd(mcuvl_pkg::ADDR_LOAD_TRIGGER, d);
    chk(d, 64'h0);
    $display("register test done");
    @(posedge i_clock) strap <= 3'h5;
    load(32'h1, 32'h1, 32'h20, 32'h0, 32'h800, 64'h0, 1'b0, 1'b1);
    chk(64'(loaded), 64'h1);
    load(32'h1, 32'h1, 32'h20, 32'h0, 32'h800, 64'h0, 1'b1, 1'b0);
    @(posedge i_clock) slow <= 1'b1;
    load(32'h1, 32'h1, 32'hFF, 32'h3D0, 32'h400, 64'h0, 1'b0, 1'b1);
    @(posedge i_clock) slow <= 1'b0;
    load(32'h1, 32'h1, 32'hDF, 32'h0, 32'h800, 64'h0, 1'b0, 1'b0);
    load(32'h1, 32'h2, 32'h20, 32'h0, 32'h800, 64'h0, 1'b0, 1'b0);
    load(32'h2, 32'h1, 32'h20, 32'h0, 32'h800, 64'h0, 1'b0, 1'b0);
    load(32'h1, 32'h1, 32'h20, 32'h0, 32'h800, 64'h8, 1'b0, 1'b0);
    load(32'h1, 32'h1, 32'h20, 32'h3D0, 32'h404, 64'h0, 1'b0, 1'b0);
    @(posedge i_clock) mwr <= 1'b1;
    maddr <= mcuvl_pkg::ADDR_LOAD_TRIGGER;
    mwdata <= 64'h2030;
    @(posedge i_clock) mwr <= 1'b0;
    repeat (20) @(posedge i_clock);
    i_init <= 1'b1;
    @(posedge i_clock) i_init <= 1'b0;
    #1 chk(64'({busy, img_rd, loaded}), 64'h1);
    $display("init abort test done");
    @(posedge i_clock) i_init <= 1'b1;
    repeat (3) @(posedge i_clock);
    i_init <= 1'b0;
    #1 chk(64'(loaded), 64'h1);
    load(32'h1, 32'h1, 32'h20, 32'h0, 32'h800, 64'h0, 1'b0, 1'b1);
    @(posedge i_clock) i_rst <= 1'b1;
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    #1 chk(64'(loaded), 64'h0);
    load(32'h1, 32'h1, 32'h20, 32'h0, 32'h800, 64'h0, 1'b0, 1'b1);
    summarize();
  end
endmodule
